// ---- sdram_decode_pkg.sv ----
// constants, register map and types shared by the burst and latency decoder
package sdram_decode_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses)
  localparam logic [7:0] OFF_MODE    = 8'h00;
  localparam logic [7:0] OFF_LAT     = 8'h04;
  localparam logic [7:0] OFF_STATUS  = 8'h08;
  localparam logic [7:0] OFF_FIFO    = 8'h0c;
  localparam logic [7:0] OFF_PATTERN = 8'h10;
  localparam logic [7:0] OFF_REFUSED = 8'h14;

  // mode_register_zero copy: field positions
  localparam int MODE_BL_LSB  = 0;
  localparam int MODE_PAR_BIT = 2;
  localparam int MODE_CRC_BIT = 3;
  localparam int MODE_DLL_BIT = 4;
  localparam int MODE_CAL_LSB = 5;

  // latency register: field positions
  localparam int LAT_CL_LSB  = 0;
  localparam int LAT_CWL_LSB = 8;
  localparam int LAT_AL_LSB  = 16;
  localparam int LAT_PL_LSB  = 24;

  // status register: field positions
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_RD_BIT   = 1;
  localparam int STAT_WR_BIT   = 2;
  localparam int STAT_OVF_BIT  = 3;
  localparam int STAT_LVL_LSB  = 4;
  localparam int STAT_RL_LSB   = 16;
  localparam int STAT_WL_LSB   = 24;

  // burst-length field encodings
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;

  // reset values
  localparam logic [1:0] BL_RST  = 2'h0;
  localparam logic [2:0] CAL_RST = 3'h0;
  localparam logic [4:0] CL_RST  = 5'h0b;
  localparam logic [4:0] CWL_RST = 5'h09;
  localparam logic [4:0] AL_RST  = 5'h00;
  localparam logic [3:0] PL_RST  = 4'h4;
  localparam logic [7:0] PAT_RST = 8'h00;

  // burst sizes in beats
  localparam logic [3:0] BEATS_8 = 4'h8;
  localparam logic [3:0] BEATS_4 = 4'h4;

  // link clock edges from delay-locked loop enable to lock
  localparam logic [7:0] DLL_LOCK_EDGES = 8'h10;

  // command codes on the link
  localparam logic [1:0] CMD_RD = 2'h1;
  localparam logic [1:0] CMD_WR = 2'h2;

  // sampled pin bus layout
  localparam int LINK_W = 14;
  localparam int P_CK   = 13;
  localparam int P_CS   = 12;
  localparam int P_CMD  = 10;
  localparam int P_A12  = 9;
  localparam int P_ODT  = 8;
  localparam int P_DQ   = 0;
  localparam logic [LINK_W-1:0] PIN_RST = 14'h1000;

  // write data buffer
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;

  typedef enum logic [1:0] {X_IDLE, X_WAIT, X_BURST} xfer_state_t;

endpackage : sdram_decode_pkg

// ---- beat_fifo.sv ----
// synchronous first-in first-out buffer for received write beats
`timescale 1ns/1ns
module beat_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic [W-1:0]              out_data,
  output logic [$clog2(D):0]        level
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW:0]   wptr_r;
  logic [AW:0]   rptr_r;
  logic          push;
  logic          pop;

  // one extra pointer bit tells full from empty
  assign level     = wptr_r - rptr_r;
  assign in_ready  = (level != D[AW:0]);
  assign out_valid = (wptr_r != rptr_r);
  assign out_data  = mem[rptr_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_r + (AW+1)'(push);
      rptr_r <= rptr_r + (AW+1)'(pop);
    end
  end

endmodule : beat_fifo

// ---- sdram_latency_burst_decode.sv ----
// burst length and read/write latency decoder of the memory device
//
// Overview of operation
// R01: burst-length field 10 forces every read and write to four-beat chop.
// R02: field 01: a command with address bit 12 low runs as four-beat chop.
// R03: field 00, or 01 with address bit 12 high, runs an eight-beat burst.
// R04: parity on: read delay is column plus additive plus parity delay.
// R05: parity on: write delay is column write plus additive plus parity delay.
// R06: parity off: delays omit parity delay, also with write checksum enabled.
// R07: chip-select latency leaves termination timing tied to the command bus.
// R08: write timing holds only with delay-locked loop enabled and locked.
// R09: controller trains write capture, else honours window plus twice skew.
// R10: with chip-select latency, command is sampled that many cycles after select.
`timescale 1ns/1ns
module sdram_latency_burst_decode
  import sdram_decode_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              link_ck,
  input  wire logic              cs_n,
  input  wire logic [1:0]        cmd,
  input  wire logic              addr_a12,
  input  wire logic              on_die_termination,
  input  wire logic [7:0]        dq_in,
  output logic      [7:0]        dq_out,
  output logic                   dq_oe,
  output logic                   dqs_out,
  output logic                   odt_on
);

  // ---------------- pin synchronisers ----------------
  logic [LINK_W-1:0] s1_r;
  logic [LINK_W-1:0] s2_r;
  logic [LINK_W-1:0] s3_r;
  logic [LINK_W-1:0] pin_r;
  logic [LINK_W-1:0] pin_nxt;
  logic              ck_prev_r;
  logic              link_edge;

  // a bit moves only once the second and third stages agree
  assign pin_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & pin_r);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1_r      <= PIN_RST;
      s2_r      <= PIN_RST;
      s3_r      <= PIN_RST;
      pin_r     <= PIN_RST;
      ck_prev_r <= 1'b0;
    end else begin
      s1_r      <= {link_ck, cs_n, cmd, addr_a12, on_die_termination, dq_in};
      s2_r      <= s1_r;
      s3_r      <= s2_r;
      pin_r     <= pin_nxt;
      ck_prev_r <= pin_r[P_CK];
    end
  end

  assign link_edge = pin_r[P_CK] & ~ck_prev_r;

  // ---------------- software registers ----------------
  logic [1:0] bl_r;
  logic       par_en_r;
  logic       crc_en_r;
  logic       dll_en_r;
  logic [2:0] cal_r;
  logic [4:0] cl_r;
  logic [4:0] cwl_r;
  logic [4:0] al_r;
  logic [3:0] pl_r;
  logic [7:0] pattern_r;
  logic       ovf_r;
  logic [7:0] refused_r;
  logic [7:0] lock_cnt_r;
  logic       dll_locked_r;

  logic wr_mode;
  logic wr_lat;
  logic wr_stat;
  logic wr_pat;
  logic wr_ref;

  assign wr_mode = reg_wr & (reg_addr == OFF_MODE);
  assign wr_lat  = reg_wr & (reg_addr == OFF_LAT);
  assign wr_stat = reg_wr & (reg_addr == OFF_STATUS);
  assign wr_pat  = reg_wr & (reg_addr == OFF_PATTERN);
  assign wr_ref  = reg_wr & (reg_addr == OFF_REFUSED);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      bl_r     <= BL_RST;
      par_en_r <= 1'b0;
      crc_en_r <= 1'b0;
      dll_en_r <= 1'b0;
      cal_r    <= CAL_RST;
    end else if (wr_mode) begin
      bl_r     <= reg_wdata[MODE_BL_LSB +: 2];
      par_en_r <= reg_wdata[MODE_PAR_BIT];
      crc_en_r <= reg_wdata[MODE_CRC_BIT];
      dll_en_r <= reg_wdata[MODE_DLL_BIT];
      cal_r    <= reg_wdata[MODE_CAL_LSB +: 3];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cl_r      <= CL_RST;
      cwl_r     <= CWL_RST;
      al_r      <= AL_RST;
      pl_r      <= PL_RST;
      pattern_r <= PAT_RST;
    end else begin
      if (wr_lat) begin
        cl_r  <= reg_wdata[LAT_CL_LSB +: 5];
        cwl_r <= reg_wdata[LAT_CWL_LSB +: 5];
        al_r  <= reg_wdata[LAT_AL_LSB +: 5];
        pl_r  <= reg_wdata[LAT_PL_LSB +: 4];
      end
      if (wr_pat) begin
        pattern_r <= reg_wdata[7:0];
      end
    end
  end

  // lock is counted in link edges: a stopped link clock never locks
  always_ff @(posedge mclk) begin
    if (!rst_n || !dll_en_r) begin
      lock_cnt_r   <= 8'h00;
      dll_locked_r <= 1'b0;
    end else if (link_edge && !dll_locked_r) begin
      lock_cnt_r   <= lock_cnt_r + 8'h01;
      dll_locked_r <= (lock_cnt_r == DLL_LOCK_EDGES - 8'h01);
    end
  end

  // ---------------- command capture ----------------
  logic       cs_low;
  logic       cal_busy_r;
  logic [2:0] cal_cnt_r;
  logic       cs_hit;
  logic       cmd_take;
  logic [1:0] cmd_f;
  logic       a12_f;
  logic       is_rd;
  logic       is_wr;

  assign cs_low = ~pin_r[P_CS];
  assign cmd_f  = pin_r[P_CMD +: 2];
  assign a12_f  = pin_r[P_A12];
  assign cs_hit = link_edge & cs_low & ~cal_busy_r & (cal_r != 3'h0);
  assign cmd_take = link_edge & ((cal_r == 3'h0) ? cs_low
                                 : (cal_busy_r & (cal_cnt_r == 3'h1))); // R10
  assign is_rd  = cmd_take & (cmd_f == CMD_RD);
  assign is_wr  = cmd_take & (cmd_f == CMD_WR);

  // select is ignored while a delayed command is still pending
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cal_busy_r <= 1'b0;
      cal_cnt_r  <= 3'h0;
    end else if (cs_hit) begin
      cal_busy_r <= 1'b1; // R10
      cal_cnt_r  <= cal_r;
    end else if (link_edge && cal_busy_r) begin
      cal_cnt_r  <= cal_cnt_r - 3'h1;
      cal_busy_r <= (cal_cnt_r != 3'h1);
    end
  end

  // ---------------- burst and latency decode ----------------
  logic       chop_w;
  logic [6:0] pl_eff;
  logic [6:0] rl_w;
  logic [6:0] wl_w;

  assign chop_w = (bl_r == BL_FIXED4) | ((bl_r == BL_OTF) & ~a12_f); // R01 R02 R03
  assign pl_eff = par_en_r ? {3'h0, pl_r} : 7'h00; // R04 R05 R06
  assign rl_w   = {2'h0, cl_r} + {2'h0, al_r} + pl_eff; // R04 R06
  assign wl_w   = {2'h0, cwl_r} + {2'h0, al_r} + pl_eff; // R05 R06

  function automatic logic [6:0] lat_load(input logic [6:0] v);
    lat_load = (v == 7'h00) ? 7'h01 : v;
  endfunction : lat_load

  // ---------------- read burst ----------------
  xfer_state_t rd_st_r;
  logic [6:0]  rd_wait_r;
  logic [3:0]  rd_left_r;
  logic [3:0]  rd_idx_r;
  logic        rd_chop_r;
  logic        rd_start;
  logic        rd_first;
  logic        rd_beat;
  logic        rd_end;

  assign rd_start = is_rd & (rd_st_r == X_IDLE);
  assign rd_first = link_edge & (rd_st_r == X_WAIT) & (rd_wait_r == 7'h01);
  assign rd_beat  = link_edge & (rd_st_r == X_BURST) & (rd_left_r != 4'h0);
  assign rd_end   = link_edge & (rd_st_r == X_BURST) & (rd_left_r == 4'h0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_st_r   <= X_IDLE;
      rd_wait_r <= 7'h00;
      rd_left_r <= 4'h0;
      rd_chop_r <= 1'b0;
    end else begin
      unique case (rd_st_r)
        X_IDLE: if (rd_start) begin
          rd_st_r   <= X_WAIT;
          rd_wait_r <= lat_load(rl_w); // R04 R06
          rd_chop_r <= chop_w; // R01 R02 R03
        end
        X_WAIT: if (rd_first) begin
          rd_st_r   <= X_BURST;
          rd_left_r <= (rd_chop_r ? BEATS_4 : BEATS_8) - 4'h1;
        end else if (link_edge) begin
          rd_wait_r <= rd_wait_r - 7'h01;
        end
        X_BURST: if (rd_end) begin
          rd_st_r <= X_IDLE;
        end else if (rd_beat) begin
          rd_left_r <= rd_left_r - 4'h1;
        end
      endcase
    end
  end

  // read beats carry the pattern plus the beat index
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dq_out   <= 8'h00;
      dq_oe    <= 1'b0;
      dqs_out  <= 1'b0;
      rd_idx_r <= 4'h0;
    end else if (rd_first || rd_beat) begin
      dq_out   <= pattern_r + {4'h0, rd_first ? 4'h0 : rd_idx_r};
      rd_idx_r <= rd_first ? 4'h1 : rd_idx_r + 4'h1;
      dq_oe    <= 1'b1;
      dqs_out  <= ~dqs_out;
    end else if (rd_end) begin
      dq_oe   <= 1'b0;
      dqs_out <= 1'b0;
    end
  end

  // ---------------- write burst ----------------
  xfer_state_t wr_st_r;
  logic [6:0]  wr_wait_r;
  logic [3:0]  wr_left_r;
  logic        wr_chop_r;
  logic        wr_start;
  logic        wr_first;
  logic        wr_beat;
  logic        wr_end;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic [4:0]  fifo_level;
  logic        fifo_pop;

  // writes are only timed against a locked loop; others are refused
  assign wr_start = is_wr & (wr_st_r == X_IDLE) & dll_locked_r; // R08
  assign wr_first = link_edge & (wr_st_r == X_WAIT) & (wr_wait_r == 7'h01);
  assign wr_beat  = link_edge & (wr_st_r == X_BURST) & (wr_left_r != 4'h0);
  assign wr_end   = link_edge & (wr_st_r == X_BURST) & (wr_left_r == 4'h0);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_st_r   <= X_IDLE;
      wr_wait_r <= 7'h00;
      wr_left_r <= 4'h0;
      wr_chop_r <= 1'b0;
    end else begin
      unique case (wr_st_r)
        X_IDLE: if (wr_start) begin
          wr_st_r   <= X_WAIT;
          wr_wait_r <= lat_load(wl_w); // R05 R06
          wr_chop_r <= chop_w; // R01 R02 R03
        end
        X_WAIT: if (wr_first) begin
          wr_st_r   <= X_BURST;
          wr_left_r <= (wr_chop_r ? BEATS_4 : BEATS_8) - 4'h1;
        end else if (link_edge) begin
          wr_wait_r <= wr_wait_r - 7'h01;
        end
        X_BURST: if (wr_end) begin
          wr_st_r <= X_IDLE;
        end else if (wr_beat) begin
          wr_left_r <= wr_left_r - 4'h1;
        end
      endcase
    end
  end

  assign fifo_pop = reg_rd & (reg_addr == OFF_FIFO);

  beat_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (wr_first | wr_beat),
    .in_ready  (fifo_in_ready),
    .in_data   (pin_r[P_DQ +: 8]),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // a full buffer drops the beat; software sees the sticky overflow bit
  logic ovf_set;
  logic ref_inc;

  assign ovf_set = (wr_first | wr_beat) & ~fifo_in_ready;
  assign ref_inc = (is_rd & (rd_st_r != X_IDLE)) | (is_wr & ~wr_start);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ovf_r     <= 1'b0;
      refused_r <= 8'h00;
    end else begin
      ovf_r <= ovf_set | (ovf_r & ~(wr_stat & reg_wdata[STAT_OVF_BIT]));
      if (ref_inc) begin
        refused_r <= wr_ref ? 8'h01 : refused_r + {7'h00, refused_r != 8'hff};
      end else if (wr_ref) begin
        refused_r <= 8'h00;
      end
    end
  end

  // termination follows the pin at every link edge, untouched by select latency
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      odt_on <= 1'b0;
    end else if (link_edge) begin
      odt_on <= pin_r[P_ODT]; // R07
    end
  end

  // ---------------- register read ----------------
  logic [DATA_W-1:0] rdata_nxt;
  logic [DATA_W-1:0] stat_w;

  assign stat_w = {1'b0, wl_w, 1'b0, rl_w, 7'h00, fifo_level, ovf_r,
                   wr_st_r != X_IDLE, rd_st_r != X_IDLE, dll_locked_r};
  assign rdata_nxt =
    (reg_addr == OFF_MODE)    ? {24'h0, cal_r, dll_en_r, crc_en_r, par_en_r, bl_r} :
    (reg_addr == OFF_LAT)     ? {4'h0, pl_r, 3'h0, al_r, 3'h0, cwl_r, 3'h0, cl_r} :
    (reg_addr == OFF_STATUS)  ? stat_w :
    (reg_addr == OFF_FIFO)    ? {23'h0, fifo_out_valid, fifo_out_data} :
    (reg_addr == OFF_PATTERN) ? {24'h0, pattern_r} :
    (reg_addr == OFF_REFUSED) ? {24'h0, refused_r} : 32'h0;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ---------------- assertions ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  fixed_chop_a: assert property ( // R01
    (rd_start && bl_r == BL_FIXED4) |=> rd_chop_r)
    else $error("fixed chop mode did not give a four-beat read");

  otf_chop_a: assert property ( // R02
    (wr_start && bl_r == BL_OTF && !a12_f) |=> wr_chop_r)
    else $error("per-command chop with a12 low did not give four beats");

  full_burst_a: assert property ( // R03
    (rd_start && (bl_r == BL_FIXED8 || (bl_r == BL_OTF && a12_f))) |=> !rd_chop_r)
    else $error("eight-beat burst expected");

  read_parity_a: assert property ( // R04
    (rd_start && par_en_r && rl_w != 7'h00)
      |=> rd_wait_r == {2'h0, cl_r} + {2'h0, al_r} + {3'h0, pl_r})
    else $error("read delay does not include parity delay");

  write_parity_a: assert property ( // R05
    (wr_start && par_en_r && wl_w != 7'h00)
      |=> wr_wait_r == {2'h0, cwl_r} + {2'h0, al_r} + {3'h0, pl_r})
    else $error("write delay does not include parity delay");

  no_parity_a: assert property ( // R06
    (wr_start && !par_en_r && wl_w != 7'h00)
      |=> wr_wait_r == {2'h0, cwl_r} + {2'h0, al_r})
    else $error("write delay wrong with parity off");

  read_drive_a: assert property ( // R04
    rd_first |=> dq_oe ##1 (dq_oe throughout (rd_st_r == X_BURST)))
    else $error("read data not driven when delay expires");

  odt_follow_a: assert property ( // R07
    link_edge |=> odt_on == $past(pin_r[P_ODT]))
    else $error("termination did not follow pin at link edge");

  write_lock_a: assert property ( // R08
    (is_wr && !dll_locked_r && wr_st_r == X_IDLE) |=> wr_st_r == X_IDLE)
    else $error("write accepted without delay-locked loop lock");

  cal_delay_a: assert property ( // R10
    cs_hit |=> (cal_busy_r && cal_cnt_r == $past(cal_r) && !cmd_take))
    else $error("select latency counter not loaded");

endmodule : sdram_latency_burst_decode

// ---- mem_ctrl_model.sv ----
// behavioural memory controller that drives the link pins of the decoder
`timescale 1ns/1ns
module mem_ctrl_model (
  output logic       link_ck,
  output logic       cs_n,
  output logic [1:0] cmd,
  output logic       addr_a12,
  output logic       on_die_termination,
  output logic [7:0] dq_in
);
  logic busy;
  time  t_cmd;

  initial begin
    {link_ck, cs_n, cmd, addr_a12, on_die_termination, dq_in, busy} = {1'b0, 1'b1, 2'h0, 1'b0, 1'b0, 8'h00, 1'b0};
    #137;
    forever #400 link_ck = ~link_ck;
  end

  // idle lines keep moving so a stale level never passes for a command or a beat
  always @(negedge link_ck) if (!busy) begin
    cmd      <= ~cmd;
    addr_a12 <= ~addr_a12;
    dq_in    <= ~dq_in;
  end

  // wl is the write total the caller worked out; beats change mid-period, away from the
  // sampling edge, which leaves the widest untrained capture window
  task automatic issue(input logic [1:0] c, input logic a12, input int cal, input int wl,
                       input int n, input logic [7:0] base);
    busy = 1'b1;
    @(negedge link_ck);
    cs_n     <= 1'b0;
    cmd      <= (cal == 0) ? c : 2'h3;
    addr_a12 <= a12;
    if (cal > 0) begin
      @(negedge link_ck);
      cs_n <= 1'b1;
      repeat (cal - 1) @(negedge link_ck);
      cmd <= c;
    end
    @(posedge link_ck);
    t_cmd = $time;
    for (int i = 1; i == 1 || i <= wl + n; i++) begin
      @(negedge link_ck);
      cs_n <= 1'b1;
      cmd  <= 2'h3;
      if (i >= wl && i < wl + n) begin
        dq_in <= base + 8'(i - wl);
      end else begin
        dq_in <= ~dq_in;
      end
    end
    @(posedge link_ck);
    busy = 1'b0;
  endtask : issue

  task automatic set_odt(input logic v);
    @(negedge link_ck);
    on_die_termination <= v;
  endtask : set_odt
endmodule : mem_ctrl_model

// ---- sdram_latency_burst_decode_tb_top.sv ----
// self-checking bench for the burst and latency decoder
`timescale 1ns/1ns
module sdram_latency_burst_decode_tb_top;
  import sdram_decode_pkg::*;
  logic              mclk, rst_n, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rd;
  logic              link_ck, cs_n, addr_a12, on_die_termination, dq_oe, dqs_out, odt_on;
  logic [1:0]        cmd;
  logic [7:0]        dq_in, dq_out;
  logic [31:0]       rnd;
  int                err_total, comparisons, cyc;

  sdram_latency_burst_decode i_sdram_latency_burst_decode (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .link_ck(link_ck), .cs_n(cs_n), .cmd(cmd), .addr_a12(addr_a12),
    .on_die_termination(on_die_termination), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .odt_on(odt_on));
  mem_ctrl_model i_mem_ctrl_model (.link_ck(link_ck), .cs_n(cs_n), .cmd(cmd),
    .addr_a12(addr_a12), .on_die_termination(on_die_termination), .dq_in(dq_in));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  function automatic int exp_beats(input int bl, input logic a12);
    return (bl == 2 || (bl == 1 && !a12)) ? 4 : 8;
  endfunction : exp_beats

  function automatic int exp_total(input int col, input int al, input int pl, input logic par);
    return (col + al + (par ? pl : 0) < 1) ? 1 : col + al + (par ? pl : 0);
  endfunction : exp_total

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_beat(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t beat=%h exp=%h", $time, got, exp);
    end
  endtask : chk_beat

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read

  task automatic read_check(input logic a12, input int cal, input int total, input int n,
                            input logic [7:0] pat);
    int   k;
    int   idx;
    logic prev;
    i_mem_ctrl_model.issue(CMD_RD, a12, cal, 0, 0, 8'h00);
    for (k = 0; k < 400 && dq_oe !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk_val(32'(($time - i_mem_ctrl_model.t_cmd) / 800), 32'(total));
    idx  = 0;
    prev = ~dqs_out;
    for (k = 0; k < 200 && dq_oe === 1'b1; k++) begin
      if (dqs_out !== prev) begin
        chk_beat(dq_out, pat + 8'(idx));
        idx++;
        prev = dqs_out;
      end
      @(posedge mclk);
      #1;
    end
    chk_val(32'(idx), 32'(n));
  endtask : read_check

  task automatic write_check(input logic a12, input int wl, input int n, input logic [7:0] b);
    i_mem_ctrl_model.issue(CMD_WR, a12, 0, wl, n, b);
    repeat (32) @(posedge mclk);
    reg_read(OFF_STATUS);
    chk_val(32'(rd[8:4]), 32'(n));
    for (int k = 0; k <= n; k++) begin
      reg_read(OFF_FIFO);
      chk_val(rd & ((k < n) ? 32'h1ff : 32'h100), (k < n) ? {23'h1, b + 8'(k)} : 32'h0);
    end
  endtask : write_check

  task automatic odt_check();
    for (int v = 1; v >= 0; v--) begin
      i_mem_ctrl_model.set_odt(v[0]);
      repeat (16) @(posedge mclk);
      #1;
      chk_val(32'(odt_on), 32'(v));
    end
  endtask : odt_check

  task automatic final_report();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ceiling well above the roughly 6000 cycles the sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    int         cl, column_write_delay, al, pl;
    logic [7:0] pat;
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    rnd         = 32'h3992;
    err_total   = 0;
    comparisons = 0;
    cyc         = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    reg_read(OFF_LAT);
    chk_val(rd, {4'h0, PL_RST, 3'h0, AL_RST, 3'h0, CWL_RST, 3'h0, CL_RST});
    reg_read(8'h18);
    chk_val(rd, 32'h0);
    // a write before the loop locks must be refused and leave the buffer empty
    i_mem_ctrl_model.issue(CMD_WR, 1'b1, 0, 9, 8, 8'h5a);
    repeat (32) @(posedge mclk);
    reg_read(OFF_REFUSED);
    chk_val(rd, 32'h1);
    reg_read(OFF_STATUS);
    chk_val(rd & 32'h7f7f01f1, 32'h090b0000);
    reg_write(OFF_MODE, 32'h10);
    repeat (160) @(posedge mclk);
    reg_read(OFF_STATUS);
    chk_val(rd & 32'h1, 32'h1);
    for (int bl = 0; bl < 3; bl++) begin
      for (int par = 0; par < 2; par++) begin
        rnd = lfsr_next(rnd);
        cl  = 5 + int'(rnd[2:0]);
        column_write_delay = 5 + int'(rnd[4:3]);
        al  = int'(rnd[6:5]);
        pl  = 1 + int'(rnd[9:7]);
        pat = rnd[23:16];
        reg_write(OFF_LAT, {4'h0, 4'(pl), 3'h0, 5'(al), 3'h0, 5'(column_write_delay), 3'h0, 5'(cl)});
        reg_write(OFF_MODE, {27'h0, 1'b1, ~par[0], par[0], 2'(bl)});
        reg_write(OFF_PATTERN, {24'h0, pat});
        reg_read(OFF_STATUS);
        chk_val(rd & 32'h7f7f0000, (32'(exp_total(column_write_delay, al, pl, par[0])) << 24) |
                (32'(exp_total(cl, al, pl, par[0])) << 16));
        for (int k = 0; k < 2; k++) begin
          read_check(k[0], 0, exp_total(cl, al, pl, par[0]), exp_beats(bl, k[0]), pat);
          write_check(k[0], exp_total(column_write_delay, al, pl, par[0]), exp_beats(bl, k[0]), ~pat);
        end
      end
    end
    reg_write(OFF_LAT, 32'h0400090b);
    odt_check();
    reg_write(OFF_MODE, 32'h70);
    read_check(1'b1, 3, 11, 8, pat);
    odt_check();
    // three bursts without draining: the buffer keeps the first sixteen beats
    reg_write(OFF_MODE, 32'h10);
    for (int k = 0; k < 3; k++) begin
      i_mem_ctrl_model.issue(CMD_WR, 1'b1, 0, 9, 8, 8'h80 + 8'(8 * k));
      repeat (32) @(posedge mclk);
    end
    reg_read(OFF_STATUS);
    chk_val(rd & 32'h1f8, 32'h108);
    // an empty buffer still shows a stale word, so only its valid bit is compared
    for (int k = 0; k < 17; k++) begin
      reg_read(OFF_FIFO);
      chk_val(rd & ((k < 16) ? 32'h1ff : 32'h100), (k < 16) ? 32'h180 + 32'(k) : 32'h0);
    end
    reg_write(OFF_STATUS, 32'h8);
    reg_read(OFF_STATUS);
    chk_val(rd & 32'h1f8, 32'h0);
    final_report();
  end
endmodule : sdram_latency_burst_decode_tb_top
